// [shift_latch_consts.vh]
// constants for the serial-in parallel-out latch
`ifndef SHIFT_LATCH_CONSTS_VH
`define SHIFT_LATCH_CONSTS_VH
`define SL_WIDTH        8
`define SL_FIRST_STAGE  0
`define SL_LAST_STAGE   7
`define SL_CLEAR_VALUE  8'h00
`define SL_STORE_RESET  8'h00
`endif

// [serial_to_parallel_latch.v]
// serial-in parallel-out shift register with storage register and 3-state outputs
`timescale 1ns/100ps
//
// Contract
// - output enable high floats parallel outputs, low drives
// - shift clock rise shifts serial input in
// - storage clock rise copies stages to storage, except while clear is low
// - simultaneous edges store old contents, then shift
// - each parallel output driven high, low or floating; cascade output always driven
// - clear low forces all stages to zero
// - last stage on cascade output, ungated
// - enable never disturbs register contents
`include "shift_latch_consts.vh"

module serial_to_parallel_latch #(
   parameter WIDTH = `SL_WIDTH
) (
   input  wire             i_clk,
   input  wire             i_nrst,
   input  wire             i_data_in_line,
   input  wire             i_shift_clock,
   input  wire             i_shift_clear_n,
   input  wire             i_storage_clock,
   input  wire             i_output_enable_n,
   output reg  [WIDTH-1:0] o_parallel_outputs,
   output reg  [WIDTH-1:0] o_parallel_outputs_oe,
   output reg              o_cascade_out
);

   reg              rst_meta_r;
   reg              rst_sync_r;
   wire             rst_n;

   // pins are asynchronous: two flops each before use
   reg  [4:0]       pin_meta_r;
   reg  [4:0]       pin_sync_r;
   reg              shift_clk_d_r;
   reg              store_clk_d_r;
   reg  [WIDTH-1:0] shift_r;
   reg  [WIDTH-1:0] shift_nxt;
   reg  [WIDTH-1:0] store_r;
   wire             ser_s;
   wire             sclk_s;
   wire             clr_n_s;
   wire             rclk_s;
   wire             oe_n_s;
   wire             shift_rise;
   wire             store_rise;

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rst_n = rst_sync_r;

   // clear and enable sync to their inactive (high) levels
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         // storage clock idles low: a high reset value would fake a store edge
         pin_meta_r <= 5'h14;
         pin_sync_r <= 5'h14;
      end else begin
         pin_meta_r <= {i_output_enable_n, i_storage_clock, i_shift_clear_n,
                        i_shift_clock, i_data_in_line};
         pin_sync_r <= pin_meta_r;
      end
   end
   assign ser_s   = pin_sync_r[0];
   assign sclk_s  = pin_sync_r[1];
   assign clr_n_s = pin_sync_r[2];
   assign rclk_s  = pin_sync_r[3];
   assign oe_n_s  = pin_sync_r[4];

   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_clk_d_r <= 1'b0;
         store_clk_d_r <= 1'b0;
      end else begin
         shift_clk_d_r <= sclk_s;
         store_clk_d_r <= rclk_s;
      end
   end
   assign shift_rise = sclk_s & ~shift_clk_d_r;
   assign store_rise = rclk_s & ~store_clk_d_r;

   always @* begin
      shift_nxt = {shift_r[WIDTH-2:0], ser_s};
   end

   // clear is level-sensitive and overrides any shift edge
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= `SL_CLEAR_VALUE;
      end else if (!clr_n_s) begin
         shift_r <= `SL_CLEAR_VALUE;
      end else if (shift_rise) begin
         shift_r <= shift_nxt;
      end
   end

   // storage sees the pre-edge shift value, so coincident edges load old data
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         store_r <= `SL_STORE_RESET;
      end else if (store_rise && clr_n_s) begin
         store_r <= shift_r;
      end
   end

   // enable gates only the pins, never the registers
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_parallel_outputs    <= `SL_STORE_RESET;
         o_parallel_outputs_oe <= {WIDTH{1'b0}};
         o_cascade_out         <= 1'b0;
      end else begin
         o_parallel_outputs    <= (store_rise && clr_n_s) ? shift_r : store_r;
         o_parallel_outputs_oe <= {WIDTH{~oe_n_s}};
         o_cascade_out         <= (!clr_n_s) ? 1'b0 :
                                  shift_rise ? shift_nxt[WIDTH-1] :
                                  shift_r[WIDTH-1];
      end
   end

endmodule // serial_to_parallel_latch

// [host_pins.sv]
// host model driving the latch pins
`timescale 1ns/100ps
module host_pins (input wire i_clk, output reg o_data = 0, o_shift = 0, o_clr_n = 1,
   o_store = 0, o_en_n = 1);
   // v packs {shift, store, data, clr_n, en_n}; 4-cycle levels outlast the pin sync
   task drive(input logic [4:0] v);
      @(posedge i_clk) {o_data, o_clr_n, o_en_n} <= v[2:0];
      @(posedge i_clk) {o_shift, o_store} <= v[4:3];
      repeat (4) @(posedge i_clk);
      {o_shift, o_store} <= 2'h0;
      repeat (4) @(posedge i_clk);
   endtask
endmodule // host_pins

// [latch_monitor.sv]
// pin checker for the latch
`timescale 1ns/100ps
module latch_monitor #(parameter WIDTH = 8) (input wire i_clk, i_nrst,
   i_shift_clock, i_shift_clear_n, i_storage_clock, i_output_enable_n, o_cascade_out,
   input wire [WIDTH-1:0] o_parallel_outputs, o_parallel_outputs_oe);
   wire s = i_shift_clock, r = i_storage_clock, k = i_shift_clear_n, c = o_cascade_out;
   wire [WIDTH-1:0] q = o_parallel_outputs, e = o_parallel_outputs_oe;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_oe_off: assert property (i_output_enable_n [*6] |-> e == '0) else $error("on");
   a_oe_on: assert property (!i_output_enable_n [*6] |-> e == '1) else $error("off");
   a_clr_zero: assert property (!k [*6] |-> !c) else $error("cascade");
   a_clr_keep: assert property (!k [*6] |-> $stable(q)) else $error("kept");
   a_store_only: assert property (!$rose(r) [*6] |-> $stable(q)) else $error("store");
   a_shift_only: assert property ((!$rose(s) && k) [*6] |-> $stable(c)) else $error("sh");
   a_store_copy: assert property ($rose(r) && !$rose(s) && k |-> ##5 q[WIDTH-1] == c)
      else $error("copy");
   a_store_old: assert property ($rose(r) && $rose(s) && k |-> ##5 q[WIDTH-2] == c)
      else $error("order");
endmodule // latch_monitor
bind serial_to_parallel_latch latch_monitor #(.WIDTH(WIDTH)) mon (.*);

// [testbench.sv]
// latch bench
`timescale 1ns/100ps
`define CHK(a, b) begin #1 checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("MISMATCH %0t %h", $time, a); end end
module testbench;
   localparam logic [7:0] P = 8'hA5;
   logic i_clk = 0, i_nrst = 0;
   wire d, s, k, r, n, c;
   wire [7:0] q, e;
   int num_errors = 0, checks_done = 0;
   host_pins host (.i_clk(i_clk), .o_data(d), .o_shift(s), .o_clr_n(k), .o_store(r), .o_en_n(n));
   serial_to_parallel_latch uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_data_in_line(d),
      .i_shift_clock(s), .i_shift_clear_n(k), .i_storage_clock(r), .i_output_enable_n(n),
      .o_parallel_outputs(q), .o_parallel_outputs_oe(e), .o_cascade_out(c));
   initial forever #10 i_clk = ~i_clk;
   task end_of_test;
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task t_load;
      for (int i = 7; i >= 0; i--) host.drive({2'h2, P[i], 2'h3});
      `CHK(c, 1'b1)
      host.drive(5'h0A);
      `CHK(q, P)
      `CHK(e, 8'hFF)
   endtask
   task t_order;  // shared edge, then a store tried under clear
      host.drive(5'h1A);
      `CHK(q, P)
      `CHK(c, P[6])
      host.drive(5'h1D);
      `CHK(q, P)
      `CHK(e, 8'h00)
      `CHK(c, 1'b0)
      host.drive(5'h0A);
      `CHK(q, 8'h00)
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      i_nrst <= 1;
      repeat (2) @(posedge i_clk);
      t_load;
      t_order;
      end_of_test;
   end
   initial begin
      #50000 num_errors++;
      end_of_test;
   end
endmodule // testbench
